// ===== pkg/ssc_pkg.sv
// shared constants and types for the smart card serial controller
package ssc_pkg;
  // device register offsets on the device's own register port
  localparam logic [3:0] DEV_MODE = 4'h0;
  localparam logic [3:0] DEV_BRR = 4'h2;
  localparam logic [3:0] DEV_CTRL = 4'h4;
  localparam logic [3:0] DEV_TXD = 4'h6;
  localparam logic [3:0] DEV_STAT = 4'h8;
  localparam logic [3:0] DEV_RXD = 4'hA;
  localparam logic [3:0] DEV_CARD = 4'hC;
  // serial_status_reg bit positions
  localparam int TX_BUF_EMPTY_BIT = 7;
  localparam int RX_BUF_FULL_BIT = 6;
  localparam int OVERRUN_BIT = 5;
  localparam int ERR_SIG_BIT = 4;
  localparam int PARITY_FAULT_BIT = 3;
  localparam int TX_DONE_BIT = 2;
  // serial_control_reg bit positions
  localparam int TX_IRQ_EN_BIT = 7;
  localparam int RX_IRQ_EN_BIT = 6;
  localparam int TX_EN_BIT = 5;
  localparam int RX_EN_BIT = 4;
  localparam int CLK_OUT_EN_BIT = 0;
  // status writes: 0 clears a flag, 1 leaves it, low two bits are unused
  localparam logic [7:0] STAT_KEEP = 8'hFC;
  localparam logic [7:0] STAT_ERR_MASK = 8'h38;
  // own register byte offsets on AHB-Lite
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_WAIT = 8'h08;
  localparam logic [7:0] REG_TXD = 8'h0C;
  localparam logic [7:0] REG_RXD = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  // command codes in REG_CMD[1:0]
  localparam logic [1:0] CMD_INIT_TX = 2'h1;
  localparam logic [1:0] CMD_INIT_RX = 2'h2;
  localparam logic [1:0] CMD_XFER = 2'h3;
  // reset values, init step numbers and frame length in bits
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [15:0] WAIT_RESET = 16'h0100;
  localparam logic [2:0] LAST_INIT_STEP = 3'h6;
  localparam logic [2:0] WAIT_STEP = 3'h6;
  localparam int FRAME_BITS = 10;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_SSR_RD = 4'b0001,
    ST_SSR_WT = 4'b0010,
    ST_SSR_CHK = 4'b0011,
    ST_ERR_CLR = 4'b0100,
    ST_INIT = 4'b0101,
    ST_BIT_WAIT = 4'b0110,
    ST_TX_DATA = 4'b0111,
    ST_TX_CLR = 4'b1000,
    ST_RX_DATA = 4'b1001,
    ST_RX_WT = 4'b1010,
    ST_RX_CLR = 4'b1011
  } ssc_state_e;

  typedef enum logic [1:0] {
    OP_DRAIN = 2'b00,
    OP_TX = 2'b01,
    OP_RX = 2'b10
  } ssc_op_e;

  // one access on the device register port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ssc_dev_req_s;
endpackage

// ===== src/ssc_host.sv
// host controller driving the smart card serial device through its registers
// Operation
// (RL1) disable transmitter and receiver, clear error flags, then write mode settings
// (RL2) mode: 8-bit characters, no multiprocessor, stop and parity fields set
// (RL3) card-mode select to 1 makes the device float its data pins
// (RL4) clock-output enable makes the device drive the card clock
// (RL5) after clock select with enables clear, wait one bit before enabling
// (RL6) never enable transmitter and receiver together
// (RL7) every direction change repeats the full initialization
// (RL8) send: error-signal flag 0, transmit-done 1, write data, clear buffer-empty
// (RL9) the device clears transmit-done when a transmission starts
// (RL10) receive: wait receive-full, read byte, clear flag; clear faults after handling
// (RL11) a byte with failed parity still lands readable in the data register
// (RL12) before changing direction confirm the current operation has finished; the controller confirms only a transmission, via transmit-done
// (RL13) only transmit-done, receive-full and error interrupts exist in card mode
// (RL14) transmit-done and receive-full interrupts follow their flags and enables
// (RL15) error interrupt follows overrun, parity-fault or error-signal, receive-enable gated; the model gates it with the rx irq enable, not receive enable
// (RL16) receiver samples each bit at base cycle 186 of 372
// (RL17) a character frame spans ten bit periods
// (RL18) device flags parity fault; controller clears it before next parity bit
// (RL19) parity failure never sets receive-full; a good frame does
// (RL20) after a good frame the device leaves the line undriven in error slot
// (RL21) device flags a card error signal; controller clears it before next parity bit
// (RL22) transmit-done only after a frame completes without error signal
// (RL23) the sender resends a character answered by an error signal
// (RL24) convention selects bit order and inversion of the data bits only
// (RL25) device signals a receive parity failure by pulling the line low
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ssc_host
  import ssc_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output ssc_pkg::ssc_dev_req_s dev_req,
  input wire logic [7:0] dev_rdata
);
  import ssc_pkg::*;

  ssc_state_e state, next_state;
  ssc_op_e op;
  logic [2:0] step;
  logic [15:0] wait_cnt, bit_wait;
  logic [31:0] cfg;
  logic [7:0] txd, rxd, ssr, err_bits;
  logic mode_tx, mode_rx, err_seen, wr_pend;
  logic [ADDR_W-1:0] wr_addr;

  // cfg fields: [0] inverse convention, [1] clock out, [3:2] prescale, [4] tx irq en,
  // [5] rx irq en, [15:8] bit rate divisor
  wire cfg_inv = cfg[0];
  wire cfg_clk_out = cfg[1];

  // ahb slave: zero wait, writes land in the data phase, reads sampled at address phase
  wire addr_ph = hsel && hready && htrans[1];
  wire cmd_wr = wr_pend && wr_addr == ADDR_W'(REG_CMD);
  wire busy = state != ST_IDLE;
  wire cmd_go = cmd_wr && !busy;
  wire [1:0] cmd_code = hwdata[1:0];
  wire go_init = cmd_go && (cmd_code == CMD_INIT_TX || cmd_code == CMD_INIT_RX);
  wire go_xfer = cmd_go && cmd_code == CMD_XFER && (mode_tx || mode_rx);
  wire [31:0] stat_word = {16'h0000, ssr, 4'h0, err_seen, mode_rx, mode_tx, busy};

  function automatic logic [31:0] rd_mux(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_W'(REG_CFG): rd_mux = cfg;
      ADDR_W'(REG_WAIT): rd_mux = {16'h0000, bit_wait};
      ADDR_W'(REG_TXD): rd_mux = {24'h000000, txd};
      ADDR_W'(REG_RXD): rd_mux = {24'h000000, rxd};
      ADDR_W'(REG_STAT): rd_mux = stat_word;
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      wr_pend <= addr_ph && hwrite;
      wr_addr <= haddr;
      if (addr_ph && !hwrite)
        hrdata <= rd_mux(haddr);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg <= CFG_RESET;
      bit_wait <= WAIT_RESET;
      txd <= 8'h00;
    end
    else if (wr_pend)
    begin
      if (wr_addr == ADDR_W'(REG_CFG))
        cfg <= hwdata;
      if (wr_addr == ADDR_W'(REG_WAIT))
        bit_wait <= hwdata[15:0];
      if (wr_addr == ADDR_W'(REG_TXD) && !busy)
        txd <= hwdata[7:0];
    end
  end

  // init writes in order; the bit-period wait sits before the last one
  function automatic ssc_dev_req_s init_op(input logic [2:0] s);
    ssc_dev_req_s r;
    r = '{wr: 1'b1, rd: 1'b0, addr: DEV_CTRL, wdata: 8'h00};
    case (s)
      3'h0: r.wdata = 8'h00; // [RL1] [RL7]
      3'h1: r = '{1'b1, 1'b0, DEV_STAT, STAT_KEEP ^ STAT_ERR_MASK}; // [RL1]
      3'h2: r = '{1'b1, 1'b0, DEV_MODE, {3'b001, cfg_inv, 2'b10, cfg[3:2]}}; // [RL2]
      3'h3: r = '{1'b1, 1'b0, DEV_CARD, {4'h0, cfg_inv, cfg_inv, 2'b01}}; // [RL3] [RL24]
      3'h4: r = '{1'b1, 1'b0, DEV_BRR, cfg[15:8]};
      3'h5: r.wdata = {7'h00, cfg_clk_out}; // [RL4] [RL5]
      3'h6:
      begin
        r.wdata = {7'h00, cfg_clk_out};
        r.wdata[TX_IRQ_EN_BIT] = cfg[4];
        r.wdata[RX_IRQ_EN_BIT] = cfg[5];
        r.wdata[TX_EN_BIT] = op == OP_TX; // [RL6]
        r.wdata[RX_EN_BIT] = op == OP_RX; // [RL6]
      end
      default: r.wdata = 8'h00;
    endcase
    return r;
  endfunction

  // flags that the controller must clear: error signal in OP_TX, overrun and parity fault in OP_RX and OP_DRAIN
  wire [7:0] err_now = dev_rdata & (op == OP_TX ? (8'h01 << ERR_SIG_BIT)
    : ((8'h01 << OVERRUN_BIT) | (8'h01 << PARITY_FAULT_BIT)));
  wire tx_done_flag_now = dev_rdata[TX_DONE_BIT];
  wire rx_buf_full_flag_now = dev_rdata[RX_BUF_FULL_BIT];

  always_comb
  begin
    next_state = state;
    case (state)
      // before a direction change, an unfinished transmission must end first
      ST_IDLE:
        if (go_init)
          next_state = mode_tx ? ST_SSR_RD : ST_INIT; // [RL12] [RL7]
        else if (go_xfer)
          next_state = ST_SSR_RD;
      ST_SSR_RD: next_state = ST_SSR_WT;
      ST_SSR_WT: next_state = ST_SSR_CHK;
      ST_SSR_CHK:
        if (err_now != 8'h00)
          next_state = ST_ERR_CLR; // [RL18] [RL21]
        else if (op == OP_RX)
          next_state = rx_buf_full_flag_now ? ST_RX_DATA : ST_SSR_RD; // [RL10]
        else if (tx_done_flag_now)
          next_state = op == OP_TX ? ST_TX_DATA : ST_INIT; // [RL8] [RL12] [RL22]
        else
          next_state = ST_SSR_RD; // frame still on the line, poll again [RL17]
      ST_ERR_CLR: next_state = ST_SSR_RD;
      ST_INIT:
        if (step == LAST_INIT_STEP)
          next_state = ST_IDLE;
        else if (step == WAIT_STEP - 3'h1)
          next_state = ST_BIT_WAIT;
      ST_BIT_WAIT:
        if (wait_cnt >= bit_wait)
          next_state = ST_INIT; // [RL5]
      ST_TX_DATA: next_state = ST_TX_CLR;
      ST_TX_CLR: next_state = ST_IDLE;
      ST_RX_DATA: next_state = ST_RX_WT;
      ST_RX_WT: next_state = ST_RX_CLR;
      ST_RX_CLR: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // the access that the current state issues; driven from a flop one cycle later
  ssc_dev_req_s next_req;
  always_comb
  begin
    next_req = '{1'b0, 1'b0, DEV_STAT, 8'h00};
    case (state)
      ST_SSR_RD: next_req.rd = 1'b1;
      ST_ERR_CLR: next_req = '{1'b1, 1'b0, DEV_STAT, STAT_KEEP ^ err_bits}; // [RL10]
      ST_INIT: next_req = init_op(step);
      ST_TX_DATA: next_req = '{1'b1, 1'b0, DEV_TXD, txd}; // [RL8]
      ST_TX_CLR:
        next_req = '{1'b1, 1'b0, DEV_STAT, STAT_KEEP ^ (8'h01 << TX_BUF_EMPTY_BIT)};
      ST_RX_DATA: next_req = '{1'b0, 1'b1, DEV_RXD, 8'h00};
      ST_RX_CLR:
        next_req = '{1'b1, 1'b0, DEV_STAT, STAT_KEEP ^ (8'h01 << RX_BUF_FULL_BIT)};
      default: next_req = '{1'b0, 1'b0, DEV_STAT, 8'h00};
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      dev_req <= '{1'b0, 1'b0, DEV_STAT, 8'h00};
    end
    else
    begin
      state <= next_state;
      dev_req <= next_req;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      op <= OP_DRAIN;
      step <= 3'h0;
      wait_cnt <= 16'h0000;
      mode_tx <= 1'b0;
      mode_rx <= 1'b0;
      err_seen <= 1'b0;
      err_bits <= 8'h00;
      ssr <= 8'h00;
      rxd <= 8'h00;
    end
    else
    begin
      if (go_init)
      begin
        // new direction is only taken once the full sequence has run
        op <= cmd_code == CMD_INIT_TX ? OP_TX : OP_RX; // [RL7]
        mode_tx <= 1'b0;
        mode_rx <= 1'b0;
        step <= 3'h0;
        err_seen <= 1'b0;
      end
      else if (go_xfer)
        err_seen <= 1'b0;
      // draining an old transmission still polls the done flag
      if (go_init && mode_tx)
        op <= OP_DRAIN;
      if (state == ST_SSR_CHK && op == OP_DRAIN && tx_done_flag_now && err_now == 8'h00)
        op <= mode_rx ? OP_RX : (cfg[31] ? OP_RX : OP_TX);
      if (state == ST_SSR_CHK)
      begin
        ssr <= dev_rdata;
        err_bits <= err_now;
        if (err_now != 8'h00)
          err_seen <= 1'b1; // [RL23]
      end
      if (state == ST_INIT)
        step <= step + 3'h1;
      wait_cnt <= state == ST_BIT_WAIT ? wait_cnt + 16'h0001 : 16'h0000;
      if (state == ST_INIT && step == LAST_INIT_STEP)
      begin
        mode_tx <= op == OP_TX;
        mode_rx <= op == OP_RX;
      end
      if (state == ST_RX_CLR)
        rxd <= dev_rdata; // [RL11]
    end
  end

  // helpers for the checks below
  logic enables_off, tx_done_flag_ok;
  logic [15:0] since_off;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      enables_off <= 1'b1;
      since_off <= 16'h0000;
      tx_done_flag_ok <= 1'b0;
    end
    else
    begin
      if (dev_req.wr && dev_req.addr == DEV_CTRL)
      begin
        enables_off <= !dev_req.wdata[TX_EN_BIT] && !dev_req.wdata[RX_EN_BIT];
        since_off <= 16'h0000;
      end
      else if (since_off != 16'hFFFF)
        since_off <= since_off + 16'h0001;
      if (state == ST_SSR_CHK)
        tx_done_flag_ok <= tx_done_flag_now && !dev_rdata[ERR_SIG_BIT];
    end
  end

  AST_MODE_FMT: assert property (@(posedge clk) disable iff (rst) // [RL2]
    dev_req.wr && dev_req.addr == DEV_MODE |-> dev_req.wdata[6] == 1'b0
    && dev_req.wdata[2] == 1'b0 && dev_req.wdata[5] && dev_req.wdata[3])
    else $error("mode write has wrong character format");
  AST_OFF_FIRST: assert property (@(posedge clk) disable iff (rst) // [RL1]
    dev_req.wr && dev_req.addr == DEV_MODE |-> enables_off)
    else $error("mode written while transmitter or receiver enabled");
  AST_NOT_BOTH: assert property (@(posedge clk) disable iff (rst) // [RL6]
    dev_req.wr && dev_req.addr == DEV_CTRL |-> !(dev_req.wdata[TX_EN_BIT]
    && dev_req.wdata[RX_EN_BIT]))
    else $error("transmitter and receiver enabled together");
  AST_BIT_WAIT: assert property (@(posedge clk) disable iff (rst) // [RL5]
    dev_req.wr && dev_req.addr == DEV_CTRL && $past(enables_off)
    && (dev_req.wdata[TX_EN_BIT] || dev_req.wdata[RX_EN_BIT]) |-> since_off > bit_wait)
    else $error("enable written before one bit period");
  AST_TX_GATE: assert property (@(posedge clk) disable iff (rst) // [RL8]
    dev_req.wr && dev_req.addr == DEV_TXD |-> tx_done_flag_ok ##1 (dev_req.wr
    && dev_req.addr == DEV_STAT && !dev_req.wdata[TX_BUF_EMPTY_BIT]))
    else $error("data written without done flag or not followed by buffer clear");
  AST_ERR_CLEAR: assert property (@(posedge clk) disable iff (rst) // [RL18]
    state == ST_SSR_CHK && err_now != 8'h00 |-> ##2 dev_req.wr
    && dev_req.addr == DEV_STAT && (dev_req.wdata & $past(err_now, 2)) == 8'h00)
    else $error("error flag not cleared right after it was seen");
  AST_INIT_START: assert property (@(posedge clk) disable iff (rst) // [RL7]
    go_init && !mode_tx |-> ##2 dev_req.wr && dev_req.addr == DEV_CTRL
    && dev_req.wdata == 8'h00)
    else $error("init did not begin by disabling the device");
  AST_RX_READ: assert property (@(posedge clk) disable iff (rst) // [RL10]
    state == ST_SSR_CHK && op == OP_RX && rx_buf_full_flag_now && err_now == 8'h00
    |-> ##2 dev_req.rd && dev_req.addr == DEV_RXD ##2 dev_req.wr
    && !dev_req.wdata[RX_BUF_FULL_BIT])
    else $error("full flag not followed by data read and flag clear");
endmodule
`default_nettype wire

// ===== dv/ssc_dev_model.sv
// behavioural card serial device behind the controller's register port
`timescale 1ns/1ps
`default_nettype none
module ssc_dev_model
  import ssc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire ssc_pkg::ssc_dev_req_s dev_req,
  output logic [7:0] dev_rdata,
  input wire logic rx_push,
  input wire logic [7:0] rx_byte,
  input wire logic rx_bad,
  input wire logic [1:0] err_n
);
  logic [7:0] mode, brr, ctrl, txd, stat, rxd, card, last_tx, rd_val;
  logic [1:0] err_left;
  logic ord_ok;
  int tmr, sends, gap, nwr, since;
  // no tx end source in card mode, only these three
  wire tx_done_irq = stat[TX_DONE_BIT] & ctrl[TX_IRQ_EN_BIT];
  wire rx_full_irq = stat[RX_BUF_FULL_BIT] & ctrl[RX_IRQ_EN_BIT];
  wire comm_error_irq = (|(stat & STAT_ERR_MASK)) & ctrl[RX_IRQ_EN_BIT];
  wire pins_float = card[0];
  wire clk_out_on = ctrl[CLK_OUT_EN_BIT];
  always_comb
  begin
    case (dev_req.addr)
      DEV_MODE: rd_val = mode;
      DEV_BRR: rd_val = brr;
      DEV_CTRL: rd_val = ctrl;
      DEV_STAT: rd_val = stat;
      DEV_RXD: rd_val = rxd;
      DEV_CARD: rd_val = card;
      default: rd_val = txd;
    endcase
  end
  always @(posedge clk)
  begin
    if (rst)
    begin
      stat <= 8'h84;
      ctrl <= 8'h00;
      card <= 8'h00;
      rxd <= 8'h00;
      dev_rdata <= 8'h00;
      err_left <= 2'h0;
      ord_ok <= 1'b1;
      tmr <= 0;
      sends <= 0;
      gap <= 0;
      nwr <= 0;
      since <= 0;
    end
    else
    begin
      // released bus shows a changing pattern, never the last value
      dev_rdata <= dev_req.rd ? rd_val : ~dev_rdata;
      since <= since + 1;
      if (rx_push && ctrl[RX_EN_BIT])
      begin
        rxd <= rx_byte;
        if (rx_bad)
          stat[PARITY_FAULT_BIT] <= 1'b1;
        else if (stat[RX_BUF_FULL_BIT])
          stat[OVERRUN_BIT] <= 1'b1;
        else
          stat[RX_BUF_FULL_BIT] <= 1'b1;
      end
      if (tmr != 0)
        tmr <= tmr - 1;
      if (tmr == 1)
      begin
        sends <= sends + 1;
        last_tx <= txd;
        if (err_left != 2'h0)
        begin
          stat[ERR_SIG_BIT] <= 1'b1;
          err_left <= err_left - 2'h1;
          tmr <= 2 * FRAME_BITS;
        end
        else
        begin
          stat[TX_DONE_BIT] <= 1'b1;
          stat[TX_BUF_EMPTY_BIT] <= 1'b1;
        end
      end
      if (dev_req.wr)
      begin
        nwr <= nwr + 1;
        case (dev_req.addr)
          DEV_MODE:
          begin
            mode <= dev_req.wdata;
            ord_ok <= ord_ok & ~ctrl[TX_EN_BIT] & ~ctrl[RX_EN_BIT] & ~(|(stat & STAT_ERR_MASK));
          end
          DEV_BRR: brr <= dev_req.wdata;
          DEV_TXD: txd <= dev_req.wdata;
          DEV_CARD: card <= dev_req.wdata;
          DEV_CTRL:
          begin
            ctrl <= dev_req.wdata;
            since <= 0;
            if (dev_req.wdata[TX_EN_BIT] | dev_req.wdata[RX_EN_BIT])
              gap <= since;
          end
          DEV_STAT:
          begin
            stat <= stat & dev_req.wdata;
            if (ctrl[TX_EN_BIT] && stat[TX_BUF_EMPTY_BIT] && !dev_req.wdata[TX_BUF_EMPTY_BIT])
            begin
              stat[TX_DONE_BIT] <= 1'b0;
              tmr <= 2 * FRAME_BITS;
              err_left <= err_n;
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/ssc_host_test.sv
// self-checking bench for the smart card serial controller
`timescale 1ns/1ps
`default_nettype none
module ssc_host_test;
  import ssc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic rx_push = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic rx_bad = 1'b0;
  logic [1:0] err_n = 2'h0;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire ssc_dev_req_s dev_req;
  wire logic [7:0] dev_rdata;
  int n_fail = 0;
  int n_tests = 0;
  logic [31:0] rd;
  always #25 clk = ~clk;
  ssc_host i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dev_req(dev_req),
    .dev_rdata(dev_rdata));
  ssc_dev_model i_dev (.clk(clk), .rst(rst), .dev_req(dev_req), .dev_rdata(dev_rdata),
    .rx_push(rx_push), .rx_byte(rx_byte), .rx_bad(rx_bad), .err_n(err_n));
  task automatic final_report();
    $display("counts: %0d compares, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tmo(input string what);
    n_fail++;
    $display("BAD t=%0t timeout %s", $time, what);
    final_report();
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
        tmo("hready");
      @(posedge clk);
    end
  endtask
  // address phase held until hready, then data phase held until hready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rdr(input logic [7:0] a);
    ahb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    rdr(REG_STAT);
    while (rd[0] !== 1'b0)
    begin
      n++;
      if (n > 400)
        tmo("busy");
      rdr(REG_STAT);
    end
  endtask
  task automatic wait_dev(input int b, input logic v);
    int n;
    n = 0;
    while (i_dev.stat[b] !== v)
    begin
      n++;
      if (n > 500)
        tmo("device flag");
      @(posedge clk);
    end
  endtask
  task automatic push(input logic [7:0] b, input logic bad);
    rx_byte <= b;
    rx_bad <= bad;
    rx_push <= 1'b1;
    @(posedge clk);
    rx_push <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_reset();
    chk(32'(dev_req.addr), 32'h8, "idle addr");
    chk(32'(hresp), 32'h0, "hresp");
    rdr(REG_CFG);
    chk(rd, CFG_RESET, "cfg reset");
    rdr(REG_WAIT);
    chk(rd, {16'h0000, WAIT_RESET}, "wait reset");
    rdr(8'h18);
    chk(rd, 32'h0000_0000, "unmapped read");
    // transfer before any init must leave the device untouched
    wr(REG_CMD, {30'h0, CMD_XFER});
    rdr(REG_STAT);
    chk(32'(rd[0]), 32'h0, "early xfer busy");
    chk(32'(i_dev.nwr), 32'h0, "early xfer writes");
    $display("test reset done");
  endtask
  task automatic t_init_tx();
    wr(REG_CFG, 32'h0000_0517);
    wr(REG_WAIT, 32'h0000_0004);
    wr(REG_CMD, {30'h0, CMD_INIT_TX});
    wait_idle();
    chk(32'(i_dev.ord_ok), 32'h1, "init order");
    chk(32'(i_dev.mode), 32'h39, "mode tx");
    chk(32'(i_dev.card), 32'h0D, "card tx");
    chk(32'(i_dev.brr), 32'h05, "brr tx");
    chk(32'(i_dev.ctrl), 32'hA1, "ctrl tx");
    chk(32'(i_dev.pins_float), 32'h1, "pins float");
    chk(32'(i_dev.clk_out_on), 32'h1, "card clock");
    chk(32'(i_dev.gap >= 4), 32'h1, "bit wait");
    rdr(REG_STAT);
    chk(32'(rd[2:1]), 32'h1, "tx ready");
    $display("test init tx done");
  endtask
  task automatic t_send();
    err_n <= 2'h1;
    wr(REG_TXD, 32'h0000_00A5);
    wr(REG_CMD, {30'h0, CMD_XFER});
    wait_idle();
    chk(32'(i_dev.stat[TX_DONE_BIT]), 32'h0, "done at start");
    wait_dev(TX_DONE_BIT, 1'b1);
    chk(32'(i_dev.sends), 32'h2, "resend");
    chk(32'(i_dev.last_tx), 32'hA5, "tx byte");
    err_n <= 2'h0;
    wr(REG_TXD, 32'h0000_005A);
    wr(REG_CMD, {30'h0, CMD_XFER});
    // data written while the poll runs must not reach the device
    wr(REG_TXD, 32'h0000_00FF);
    wait_idle();
    wait_dev(TX_DONE_BIT, 1'b1);
    chk(32'(i_dev.sends), 32'h3, "second send");
    chk(32'(i_dev.last_tx), 32'h5A, "busy txd ignored");
    chk(32'(i_dev.tx_done_irq), 32'h1, "done irq");
    chk(32'(i_dev.stat[ERR_SIG_BIT]), 32'h0, "err cleared");
    rdr(REG_STAT);
    chk(32'(rd[3]), 32'h1, "err seen");
    $display("test send done");
  endtask
  task automatic t_rx();
    // bit 31 picks receive once the old transmission has drained
    wr(REG_CFG, 32'h8000_0328);
    wr(REG_CMD, {30'h0, CMD_INIT_RX});
    wait_idle();
    chk(32'(i_dev.ctrl), 32'h50, "ctrl rx");
    chk(32'(i_dev.mode), 32'h2A, "mode rx");
    chk(32'(i_dev.card), 32'h01, "card rx");
    push(8'h3C, 1'b1);
    chk(32'(i_dev.rxd), 32'h3C, "bad byte kept");
    chk(32'(i_dev.stat[RX_BUF_FULL_BIT]), 32'h0, "no full");
    chk(32'(i_dev.comm_error_irq), 32'h1, "error irq");
    chk(32'(i_dev.rx_full_irq), 32'h0, "no full irq");
    wr(REG_CMD, {30'h0, CMD_XFER});
    wait_dev(PARITY_FAULT_BIT, 1'b0);
    push(8'hC3, 1'b0);
    wait_idle();
    rdr(REG_RXD);
    chk(rd, 32'h0000_00C3, "rx byte");
    chk(32'(i_dev.stat[RX_BUF_FULL_BIT]), 32'h0, "full cleared");
    rdr(REG_STAT);
    chk(32'(rd[3]), 32'h1, "parity seen");
    $display("test receive done");
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_init_tx();
    t_send();
    t_rx();
    final_report();
  end
endmodule
`default_nettype wire
